// ===== design/tmc_pkg.sv
// constants and types shared by the three-timer block
package tmc_pkg;

  // ---------------------------------------------------------------
  // timer instances
  // ---------------------------------------------------------------
  localparam int NUM_TMR = 3;
  localparam int TMR_COMPACT = 0;
  localparam int TMR_STANDARD = 1;
  localparam int TMR_PERIODIC = 2;

  // ---------------------------------------------------------------
  // register map: address[6:5] picks the timer, address[4:2] the register
  // ---------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int TSEL_LSB = 5;
  localparam int RSEL_LSB = 2;
  localparam logic [2:0] REG_CTRL0 = 3'h0;
  localparam logic [2:0] REG_CTRL1 = 3'h1;
  localparam logic [2:0] REG_CNT_LO = 3'h2;
  localparam logic [2:0] REG_CNT_HI = 3'h3;
  localparam logic [2:0] REG_CMPA_LO = 3'h4;
  localparam logic [2:0] REG_CMPA_HI = 3'h5;
  localparam logic [2:0] REG_PER_LO = 3'h6;
  localparam logic [2:0] REG_PER_HI = 3'h7;

  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int C0_PAUSE = 7;
  localparam int C0_CKSEL_LSB = 4;
  localparam int C0_ON = 3;
  localparam int C1_MODE_LSB = 6;
  localparam int C1_IO_LSB = 4;
  localparam int C1_OC = 3;
  localparam int C1_POL = 2;
  localparam int C1_CCLR = 0;
  localparam logic [7:0] C0_WMASK = 8'hf8;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00, MODE_CAP = 2'b01, MODE_PWM = 2'b10, MODE_TMR = 2'b11
  } tmc_mode_e;
  typedef enum logic [2:0] {
    CK_SYS4 = 3'h0, CK_SYS = 3'h1, CK_H16 = 3'h2, CK_H64 = 3'h3,
    CK_SUB0 = 3'h4, CK_SUB1 = 3'h5, CK_EXT_R = 3'h6, CK_EXT_F = 3'h7
  } tmc_cksel_e;
  typedef enum logic [1:0] {SP_IDLE = 2'b00, SP_RUN = 2'b01} tmc_pulse_e;

  localparam logic [1:0] IO_NONE = 2'b00;
  localparam logic [1:0] IO_LOW = 2'b01;
  localparam logic [1:0] IO_HIGH = 2'b10;
  localparam logic [1:0] IO_TOG = 2'b11;
  localparam logic [1:0] IO_INACT = 2'b00;
  localparam logic [1:0] IO_ACT = 2'b01;
  localparam logic [1:0] IO_PWM = 2'b10;
  localparam logic [1:0] IO_SINGLE = 2'b11;
  localparam logic [1:0] CAP_RISE = 2'b00;
  localparam logic [1:0] CAP_FALL = 2'b01;
  localparam logic [1:0] CAP_BOTH = 2'b10;

  // ---------------------------------------------------------------
  // clock ratios (high clock taken as the core clock)
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int SUB_HZ = 32_768;
  localparam int SUB_DIV = CLK_HZ / SUB_HZ;
  localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);
  localparam int DIV_SYS4 = 4;
  localparam int DIV_H16 = 16;
  localparam int DIV_H64 = 64;

endpackage

// ===== design/tmc_pin_edge.sv
// synchroniser and edge detector for one timer input pin
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_edge
  import tmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  output logic o_rise,
  output logic o_fall
);
  logic meta_q, sync_q, prev_q, rise_q, fall_q;
  logic rise_d, fall_d;

  // first stage feeds only the second stage
  always_comb begin
    rise_d = sync_q & ~prev_q;
    fall_d = ~sync_q & prev_q;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign o_rise = rise_q;
  assign o_fall = fall_q;
endmodule
`default_nettype wire

// ===== design/tmc_prescaler.sv
// shared divider making the internal count ticks
`timescale 1ns/100ps
`default_nettype none
module tmc_prescaler
  import tmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  output logic [3:0] o_tick
);
  logic [5:0] div_q, div_d;
  logic [11:0] sub_q, sub_d;
  logic [3:0] tick_q, tick_d;

  always_comb begin
    div_d = div_q + 6'h1;
    sub_d = (sub_q == SUB_LAST) ? 12'h000 : sub_q + 12'h001;
    tick_d[0] = div_q[1:0] == 2'(DIV_SYS4 - 1);
    tick_d[1] = div_q[3:0] == 4'(DIV_H16 - 1);
    tick_d[2] = div_q == 6'(DIV_H64 - 1);
    tick_d[3] = sub_q == SUB_LAST;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q <= 6'h00;
      sub_q <= 12'h000;
      tick_q <= 4'h0;
    end else begin
      div_q <= div_d;
      sub_q <= sub_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule
`default_nettype wire

// ===== design/tmc_timer_top.sv
// three timer modules behind one register slave
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_top
  import tmc_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_compact_ext_clock_pin,
  input wire logic i_standard_ext_clock_pin,
  input wire logic i_standard_capture_pin,
  input wire logic i_periodic_capture_pin,
  output logic o_compact_out_pin,
  output logic o_compact_out_inv_pin,
  output logic o_standard_out_pin,
  output logic o_standard_out_inv_pin,
  output logic o_periodic_out_signal,
  output logic [NUM_TMR-1:0] o_irq_a,
  output logic [NUM_TMR-1:0] o_irq_p
);
  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_q, rst_n_q;

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // pins and count ticks
  // ---------------------------------------------------------------
  logic [3:0] pin_in, pin_rise, pin_fall, pre_tick;
  logic [NUM_TMR-1:0] clk_rise, clk_fall, cap_rise, cap_fall;

  assign pin_in = {i_periodic_capture_pin, i_standard_capture_pin,
                   i_standard_ext_clock_pin, i_compact_ext_clock_pin};

  for (genvar g = 0; g < 4; g++) begin : g_pin
    tmc_pin_edge u_edge (
      .i_core_clk(i_core_clk),
      .i_rst_n(rst_n_q),
      .i_pin(pin_in[g]),
      .o_rise(pin_rise[g]),
      .o_fall(pin_fall[g])
    );
  end

  // periodic timer has no external clock, compact no capture input
  assign clk_rise = {1'b0, pin_rise[1], pin_rise[0]};
  assign clk_fall = {1'b0, pin_fall[1], pin_fall[0]};
  assign cap_rise = {pin_rise[3], pin_rise[2], 1'b0};
  assign cap_fall = {pin_fall[3], pin_fall[2], 1'b0};

  tmc_prescaler u_pre (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n_q),
    .o_tick(pre_tick)
  );

  function automatic logic pick_tick(input logic [2:0] sel, input logic [3:0] pt,
                                     input logic r, input logic f);
    logic t;
    case (tmc_cksel_e'(sel))
      CK_SYS4: t = pt[0];
      CK_SYS: t = 1'b1;
      CK_H16: t = pt[1];
      CK_H64: t = pt[2];
      CK_EXT_R: t = r;
      CK_EXT_F: t = f;
      default: t = pt[3];
    endcase
    return t;
  endfunction

  function automatic logic cap_edge(input logic [1:0] io, input logic r, input logic f);
    return (io == CAP_RISE && r) || (io == CAP_FALL && f) || (io == CAP_BOTH && (r || f));
  endfunction

  // ---------------------------------------------------------------
  // bus handshake: one wait cycle, then the answer
  // ---------------------------------------------------------------
  logic req, prep, wr_do, in_map;
  logic [1:0] tsel;
  logic [2:0] rsel;
  logic [7:0] wbyte;

  assign req = i_avs_read | i_avs_write;
  assign prep = req & o_avs_waitrequest;
  assign wr_do = i_avs_write & ~o_avs_waitrequest;
  assign tsel = i_avs_address[TSEL_LSB +: 2];
  assign rsel = i_avs_address[RSEL_LSB +: 3];
  assign in_map = tsel < 2'(NUM_TMR);
  assign wbyte = i_avs_writedata[7:0];

  // ---------------------------------------------------------------
  // timer state
  // ---------------------------------------------------------------
  logic [7:0] ctrl0_q [NUM_TMR], ctrl0_d [NUM_TMR];
  logic [7:0] ctrl1_q [NUM_TMR], ctrl1_d [NUM_TMR];
  logic [7:0] buf_q [NUM_TMR], buf_d [NUM_TMR];
  logic [15:0] cnt_q [NUM_TMR], cnt_d [NUM_TMR];
  logic [15:0] cmpa_q [NUM_TMR], cmpa_d [NUM_TMR];
  logic [15:0] per_q [NUM_TMR], per_d [NUM_TMR];
  tmc_pulse_e sp_q [NUM_TMR], sp_d [NUM_TMR];
  logic [NUM_TMR-1:0] on_prev_q, on_prev_d, lvl_q, lvl_d, pin_q, pin_d;
  logic [NUM_TMR-1:0] irq_a_q, irq_a_d, irq_p_q, irq_p_d;
  logic [1:0] pinb_q, pinb_d;
  logic [31:0] rdata_q, rdata_d;
  logic wait_d;

  always_comb begin
    logic sel, on, on_rise, single, trig, run, a_hit, p_hit, m_a, m_p, cap, act, lvl;
    logic [1:0] io;
    tmc_mode_e mode;
    sel = 1'b0;
    on = 1'b0;
    on_rise = 1'b0;
    single = 1'b0;
    trig = 1'b0;
    run = 1'b0;
    a_hit = 1'b0;
    p_hit = 1'b0;
    m_a = 1'b0;
    m_p = 1'b0;
    cap = 1'b0;
    act = 1'b0;
    lvl = 1'b0;
    io = 2'b00;
    mode = MODE_CMP;
    wait_d = ~prep;
    rdata_d = rdata_q;
    if (prep && i_avs_read && !in_map) begin
      rdata_d = 32'h0000_0000;
    end
    for (int t = 0; t < NUM_TMR; t++) begin
      ctrl0_d[t] = ctrl0_q[t];
      ctrl1_d[t] = ctrl1_q[t];
      buf_d[t] = buf_q[t];
      cnt_d[t] = cnt_q[t];
      cmpa_d[t] = cmpa_q[t];
      per_d[t] = per_q[t];
      sp_d[t] = sp_q[t];
      sel = in_map && (tsel == 2'(t));
      mode = tmc_mode_e'(ctrl1_q[t][C1_MODE_LSB +: 2]);
      io = ctrl1_q[t][C1_IO_LSB +: 2];
      on = ctrl0_q[t][C0_ON];
      on_rise = on && !on_prev_q[t];
      on_prev_d[t] = on;
      single = (t == TMR_STANDARD) && (mode == MODE_PWM) && (io == IO_SINGLE);
      trig = single && on && clk_rise[t] && (sp_q[t] == SP_IDLE);
      run = on && !ctrl0_q[t][C0_PAUSE] && (!single || sp_q[t] == SP_RUN) &&
            pick_tick(ctrl0_q[t][C0_CKSEL_LSB +: 3], pre_tick, clk_rise[t], clk_fall[t]);
      a_hit = cnt_q[t] == cmpa_q[t];
      p_hit = (t == TMR_PERIODIC) ? (cnt_q[t] == per_q[t]) :
              (cnt_q[t] == {per_q[t][15:8], 8'hff});
      m_a = run && a_hit && (mode != MODE_CAP);
      m_p = run && p_hit && (mode != MODE_CAP);
      cap = on && (mode == MODE_CAP) && cap_edge(io, cap_rise[t], cap_fall[t]);
      irq_a_d[t] = m_a || cap;
      irq_p_d[t] = m_p;
      if (on_rise || trig) begin
        cnt_d[t] = 16'h0000;
      end else if (run) begin
        if (ctrl1_q[t][C1_CCLR] ? m_a : m_p) begin
          cnt_d[t] = 16'h0000;
        end else begin
          cnt_d[t] = cnt_q[t] + 16'h0001;
        end
      end
      if (cap) begin
        cmpa_d[t] = cnt_q[t];
      end
      if (!single) begin
        sp_d[t] = SP_IDLE;
      end else if (trig) begin
        sp_d[t] = SP_RUN;
      end else if (m_a) begin
        sp_d[t] = SP_IDLE;
      end
      // output level before polarity; timer and capture modes hold it
      lvl = lvl_q[t];
      act = 1'b0;
      case (mode)
        MODE_CMP: begin
          if (on_rise) begin
            lvl = ctrl1_q[t][C1_OC];
          end else if (m_a) begin
            case (io)
              IO_LOW: lvl = 1'b0;
              IO_HIGH: lvl = 1'b1;
              IO_TOG: lvl = ~lvl_q[t];
              default: lvl = lvl_q[t];
            endcase
          end
        end
        MODE_PWM: begin
          case (io)
            IO_INACT: act = 1'b0;
            IO_ACT: act = 1'b1;
            IO_PWM: act = on && (cnt_q[t] < cmpa_q[t]);
            default: act = sp_q[t] == SP_RUN;
          endcase
          lvl = act ? ctrl1_q[t][C1_OC] : ~ctrl1_q[t][C1_OC];
        end
        default: lvl = lvl_q[t];
      endcase
      lvl_d[t] = lvl;
      pin_d[t] = lvl ^ ctrl1_q[t][C1_POL];
      // register writes take effect at the answer edge
      if (wr_do && sel) begin
        case (rsel)
          REG_CTRL0: ctrl0_d[t] = wbyte & C0_WMASK;
          REG_CTRL1: ctrl1_d[t] = wbyte;
          REG_CMPA_LO, REG_PER_LO: buf_d[t] = wbyte;
          REG_CMPA_HI: cmpa_d[t] = {wbyte, buf_q[t]};
          REG_PER_HI: per_d[t] = {wbyte, buf_q[t]};
          default: buf_d[t] = buf_q[t];
        endcase
      end
      // reads latch the low byte at the same edge the high byte is sampled
      if (prep && i_avs_read && sel) begin
        case (rsel)
          REG_CTRL0: rdata_d = {24'h000000, ctrl0_q[t]};
          REG_CTRL1: rdata_d = {24'h000000, ctrl1_q[t]};
          REG_CNT_HI: begin
            rdata_d = {24'h000000, cnt_q[t][15:8]};
            buf_d[t] = cnt_q[t][7:0];
          end
          REG_CMPA_HI: begin
            rdata_d = {24'h000000, cmpa_q[t][15:8]};
            buf_d[t] = cmpa_q[t][7:0];
          end
          REG_PER_HI: begin
            rdata_d = {24'h000000, per_q[t][15:8]};
            buf_d[t] = per_q[t][7:0];
          end
          default: rdata_d = {24'h000000, buf_q[t]};
        endcase
      end
    end
    pinb_d = ~pin_d[1:0];
  end

  always_ff @(posedge i_core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int t = 0; t < NUM_TMR; t++) begin
        ctrl0_q[t] <= RST_CTRL;
        ctrl1_q[t] <= RST_CTRL;
        buf_q[t] <= RST_CTRL;
        cnt_q[t] <= RST_WORD;
        cmpa_q[t] <= RST_WORD;
        per_q[t] <= RST_WORD;
        sp_q[t] <= SP_IDLE;
      end
      on_prev_q <= 3'h0;
      lvl_q <= 3'h0;
      pin_q <= 3'h0;
      irq_a_q <= 3'h0;
      irq_p_q <= 3'h0;
      pinb_q <= 2'h3;
      rdata_q <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      cmpa_q <= cmpa_d;
      per_q <= per_d;
      sp_q <= sp_d;
      on_prev_q <= on_prev_d;
      lvl_q <= lvl_d;
      pin_q <= pin_d;
      irq_a_q <= irq_a_d;
      irq_p_q <= irq_p_d;
      pinb_q <= pinb_d;
      rdata_q <= rdata_d;
      o_avs_waitrequest <= wait_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_compact_out_pin = pin_q[TMR_COMPACT];
  assign o_compact_out_inv_pin = pinb_q[TMR_COMPACT];
  assign o_standard_out_pin = pin_q[TMR_STANDARD];
  assign o_standard_out_inv_pin = pinb_q[TMR_STANDARD];
  assign o_periodic_out_signal = pin_q[TMR_PERIODIC];
  assign o_irq_a = irq_a_q;
  assign o_irq_p = irq_p_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic hit_a0, hit_p2, on0, lo_wr0, cnthi_rd0;
  logic [7:0] cnt_lo0, buf0;
  logic [15:0] cmpa0;
  assign hit_a0 = cnt_q[0] == cmpa_q[0];
  assign hit_p2 = cnt_q[2] == per_q[2];
  assign on0 = ctrl0_q[0][C0_ON];
  assign cnt_lo0 = cnt_q[0][7:0];
  assign buf0 = buf_q[0];
  assign cmpa0 = cmpa_q[0];
  assign lo_wr0 = wr_do && tsel == 2'h0 && rsel == REG_CMPA_LO;
  assign cnthi_rd0 = prep && i_avs_read && tsel == 2'h0 && rsel == REG_CNT_HI;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n_q);

  sequence s_lo_write;
    lo_wr0 ##1 1'b1;
  endsequence

  a_wait_one_cycle: assert property (prep |=> !o_avs_waitrequest)
    else $error("answer not given one cycle after request");
  a_wait_released: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest stayed low");
  a_on_clears_count: assert property ($rose(on0) |=> cnt_q[0] == 16'h0000)
    else $error("counter not cleared on enable");
  a_irq_a_cause: assert property (irq_a_q[0] |-> $past(hit_a0))
    else $error("comparator A request without a match");
  a_irq_p_cause: assert property (irq_p_q[2] |-> $past(hit_p2))
    else $error("comparator P request without a match");
  a_high_latches_low: assert property (cnthi_rd0 |=> buf0 == $past(cnt_lo0))
    else $error("low byte not latched on high read");
  a_low_write_held: assert property (s_lo_write |-> $stable(cmpa0) && buf0 == $past(wbyte))
    else $error("low byte write reached the compare register");
  a_toggle_on_match: assert property (irq_a_q[0] && $past(ctrl1_q[0][7:4] == 4'h3)
                                      |-> o_compact_out_pin != $past(o_compact_out_pin))
    else $error("compact pin did not toggle on match");
  a_inv_pin_pair: assert property (o_compact_out_inv_pin == !o_compact_out_pin)
    else $error("inverted compact pin out of step");
endmodule
`default_nettype wire

// ===== tb/tmc_pin_model.sv
// behavioural source for the timer clock and capture pins
`timescale 1ns/100ps
`default_nettype none
module tmc_pin_model (
  input wire logic i_core_clk,
  input wire logic [3:0] i_fire,
  output logic [3:0] o_pin
);
  logic [2:0] cnt_q [4];
  initial begin
    for (int j = 0; j < 4; j++) cnt_q[j] = 3'h0;
  end
  // one request gives 3 cycles high then 3 low, so both edges stay sampleable
  always @(posedge i_core_clk) begin
    for (int j = 0; j < 4; j++) begin
      if (cnt_q[j] != 3'h0) cnt_q[j] <= cnt_q[j] - 3'h1;
      else if (i_fire[j]) cnt_q[j] <= 3'h6;
    end
  end
  always_comb begin
    for (int j = 0; j < 4; j++) o_pin[j] = (cnt_q[j] > 3'h3);
  end
endmodule
`default_nettype wire

// ===== tb/tmc_timer_top_tb.sv
// self-checking bench for the three-timer block
`timescale 1ns/100ps
`default_nettype none
module tmc_timer_top_tb
  import tmc_pkg::*;
();
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] e;} tmc_row_s;
  logic clk, rst_n, rd, wr, wreq, cpin, cinv, spin, sinv, ppin;
  logic [6:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] fire, pin;
  logic [2:0] irq_a, irq_p;
  logic [7:0] q;
  int n_errors, compares, k, i;
  tmc_row_s rows [5] = '{'{7'h00, 8'hf7, 8'hf0}, '{7'h24, 8'hfd, 8'hfd},
    '{7'h2c, 8'h77, 8'h00}, '{7'h60, 8'hff, 8'h00}, '{7'h44, 8'h7d, 8'h7d}};
  logic [7:0] cmp_cfg [3] = '{8'h31, 8'h21, 8'h19};
  logic cmp_exp [3] = '{1'b1, 1'b1, 1'b0};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pin sharing sits outside the block, so the model drives the timer inputs straight
  tmc_pin_model pm (.i_core_clk(clk), .i_fire(fire), .o_pin(pin));
  tmc_timer_top dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_compact_ext_clock_pin(pin[0]),
    .i_standard_ext_clock_pin(pin[1]), .i_standard_capture_pin(pin[2]),
    .i_periodic_capture_pin(pin[3]), .o_compact_out_pin(cpin), .o_compact_out_inv_pin(cinv),
    .o_standard_out_pin(spin), .o_standard_out_inv_pin(sinv),
    .o_periodic_out_signal(ppin), .o_irq_a(irq_a), .o_irq_p(irq_p));

  // ---------------------------------------------------------------
  // checks and bus tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    compares++;
    if (got != exp) begin
      n_errors++;
      $display("[ERR] %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    adr <= a;
    wdat <= {24'h0, d};
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n >= 40) begin
      n_errors++;
      $display("[ERR] %0t bus hang", $time);
      close_out();
    end
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic wpair(input logic [6:0] lo, input logic [15:0] v);
    wreg(lo, v[7:0]);
    wreg(lo + 7'h4, v[15:8]);
  endtask
  task automatic chkpair(input logic [6:0] lo, input logic [15:0] e);
    bus(1'b0, lo + 7'h4, 8'h00);
    chk8(q, e[15:8]);
    bus(1'b0, lo, 8'h00);
    chk8(q, e[7:0]);
  endtask
  function automatic logic hit(input int sel, input int idx);
    hit = (sel == 0) ? irq_a[idx] : (sel == 1) ? irq_p[idx] : (sel == 2) ? cpin : spin;
  endfunction
  task automatic cnt(input int sel, input int idx, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(negedge clk);
      n += int'(hit(sel, idx) === 1'b1);
    end
    @(posedge clk);
  endtask
  task automatic wpulse(input int sel, input int idx, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (hit(sel, idx) !== 1'b1 && n < 600);
    if (n >= 600) begin
      n_errors++;
      $display("[ERR] %0t no interrupt", $time);
      close_out();
    end
  endtask
  task automatic pulse(input int j, input int n);
    repeat (n) begin
      fire[j] <= 1'b1;
      @(posedge clk);
      fire[j] <= 1'b0;
      repeat (12) @(posedge clk);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 7'h00;
    wdat = 32'h0;
    fire = 4'h0;
    n_errors = 0;
    compares = 0;
    repeat (8) @(posedge clk);
    chk8({3'h0, cpin, cinv, spin, sinv, ppin}, 8'h0a);
    chk8({2'h0, irq_a, irq_p}, 8'h00);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[r]) begin
      wreg(rows[r].a, rows[r].d);
      bus(1'b0, rows[r].a, 8'h00);
      chk8(q, rows[r].e);
      wreg(rows[r].a, 8'h00);
    end
    wpair(7'h10, 16'h1234);
    chkpair(7'h10, 16'h1234);
    wreg(7'h10, 8'h56);
    chkpair(7'h10, 16'h1234);
    wpair(7'h58, 16'h0004);
    chkpair(7'h58, 16'h0004);
    // one match only: counter is stopped well before the next one
    wpair(7'h10, 16'h0005);
    for (i = 0; i < 3; i++) begin
      wreg(7'h04, cmp_cfg[i]);
      wreg(7'h00, 8'h18);
      wpulse(0, 0, k);
      @(posedge clk);
      wreg(7'h00, 8'h00);
      chk8({6'h0, cpin, cinv}, {6'h0, cmp_exp[i], ~cmp_exp[i]});
    end
    wreg(7'h04, 8'h01);
    wreg(7'h00, 8'h18);
    wpulse(0, 0, k);
    wpulse(0, 0, k);
    @(posedge clk);
    chkn(k, 6);
    wreg(7'h00, 8'h00);
    wreg(7'h04, 8'ha8);
    wreg(7'h00, 8'h18);
    cnt(2, 0, 100, k);
    cnt(2, 0, 256, k);
    chkn(k, 5);
    wreg(7'h00, 8'h00);
    wreg(7'h44, 8'hc0);
    wreg(7'h40, 8'h18);
    wpulse(1, 2, k);
    wpulse(1, 2, k);
    @(posedge clk);
    chkn(k, 5);
    wreg(7'h40, 8'h00);
    // compact counts three rising pin edges; the high read latches its low byte
    wreg(7'h04, 8'hc0);
    wreg(7'h00, 8'h68);
    pulse(0, 3);
    wreg(7'h00, 8'h00);
    chkpair(7'h08, 16'h0003);
    for (i = 0; i < 2; i++) begin
      wreg(7'h24, 8'hc0);
      wreg(7'h20, (i == 0) ? 8'h68 : 8'h78);
      pulse(1, 3);
      wreg(7'h20, 8'h00);
      chkpair(7'h28, 16'h0003);
    end
    // single pulse: one trigger edge gives one pulse lasting until the A match
    wreg(7'h24, 8'hb9);
    wpair(7'h30, 16'h0008);
    wreg(7'h20, 8'h18);
    fire[1] <= 1'b1;
    @(posedge clk);
    fire[1] <= 1'b0;
    cnt(3, 0, 40, k);
    chkn(k, 9);
    wreg(7'h20, 8'h00);
    wreg(7'h40, 8'h18);
    for (i = 0; i < 3; i++) begin
      wreg(7'h44, {2'b01, 2'(i), 4'h0});
      fire[3] <= 1'b1;
      @(posedge clk);
      fire[3] <= 1'b0;
      cnt(0, 2, 24, k);
      chkn(k, (i == 2) ? 2 : 1);
    end
    // reset in mid-run: outputs fall back at once, control comes back cleared
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk8({3'h0, cpin, cinv, spin, sinv, ppin}, 8'h0a);
    chk8({2'h0, irq_a, irq_p}, 8'h00);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 7'h40, 8'h00);
    chk8(q, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
